//--- rtl/gripper_regs_pkg.sv
// Constants for the gripper control and status register bank
// ============================================================
// Overview of operation
// - Power-up leaves the gripper active, moving allowed, GPIO-driven.
// - GPIO mode: command low drives to close preset, high to open preset.
// - Preset defaults are open 120 mm and close 10 mm.
// - Mode bit 0 activates; while clear all other mode bits are ignored.
// - Mode bit 1 allows motion; when clear the fingers hold in place.
// - Mode bit 2 picks the source: 0 serial registers, 1 GPIO pin.
// - Mode bits 3 to 15 have no effect.
// - Target is doubled millimetres, 16 bits, limited to 0..132 mm.
// - Speed and torque use the low byte only, 255 is full scale.
// - Close and open presets are 0..255, doubled millimetres.
// - Status bit 0 shows activation, bit 1 shows motion permitted.
// - Status bits 2-3 show source: 00 serial, 01 GPIO.
// - Status bits 4-5 show object detection code.
// - Status bit 6 mirrors the GPIO command input level.
// - Status bit 7 is 1 while fingers move.
// - Status bits 8-15 hold the fault code 0..5.
// - Echoed target returns the last value written to the target.
// - Measured position returns encoder distance in doubled mm.
// - Motor current register returns tenths of an ampere.
// - Temperature register: sensor A upper byte, sensor B lower byte.
// - Link 115200 baud 8N1, server address 86, functions 04, 06, 16.
package gripper_regs_pkg;

  // ============================================================
  // Register offsets
  localparam logic [15:0] ADDR_STATE_FLAGS   = 16'h03E8;
  localparam logic [15:0] ADDR_ECHO_TARGET   = 16'h03E9;
  localparam logic [15:0] ADDR_MEASURED_POS  = 16'h03EA;
  localparam logic [15:0] ADDR_MOTOR_CURRENT = 16'h03EB;
  localparam logic [15:0] ADDR_DUAL_TEMP     = 16'h03EC;
  localparam logic [15:0] ADDR_STATUS_RSVD   = 16'h03ED;
  localparam logic [15:0] ADDR_MODE          = 16'h07D0;
  localparam logic [15:0] ADDR_TARGET        = 16'h07D1;
  localparam logic [15:0] ADDR_SPEED         = 16'h07D2;
  localparam logic [15:0] ADDR_TORQUE        = 16'h07D3;
  localparam logic [15:0] ADDR_PRESET_CLOSE  = 16'h07D4;
  localparam logic [15:0] ADDR_PRESET_OPEN   = 16'h07D5;

  // ============================================================
  // Mode register fields
  localparam int ACTIVATE_BIT      = 0;
  localparam int MOTION_ENABLE_BIT = 1;
  localparam int SOURCE_BIT        = 2;

  // ============================================================
  // Status register fields
  localparam int ACTIVE_FLAG_POS    = 0;
  localparam int MOTION_ALLOWED_POS = 1;
  localparam int SOURCE_FIELD_LSB   = 2;
  localparam int OBJECT_FIELD_LSB   = 4;
  localparam int PIN_ECHO_POS       = 6;
  localparam int MOVING_FLAG_POS    = 7;
  localparam int FAULT_FIELD_LSB    = 8;
  localparam logic [1:0] SOURCE_SERIAL = 2'h0;
  localparam logic [1:0] SOURCE_GPIO   = 2'h1;

  // ============================================================
  // Reset values
  localparam logic [15:0] MODE_RESET         = 16'h0007;
  localparam logic [15:0] TARGET_RESET       = 16'h0000;
  localparam logic [7:0]  SPEED_RESET        = 8'h7F;
  localparam logic [7:0]  TORQUE_RESET       = 8'h7F;
  localparam logic [7:0]  PRESET_CLOSE_RESET = 8'h14;
  localparam logic [7:0]  PRESET_OPEN_RESET  = 8'hF0;

  // ============================================================
  // Limits
  localparam logic [15:0] TARGET_LIMIT = 16'h0108;

  // ============================================================
  // Serial link
  localparam logic [7:0] SERVER_ADDR   = 8'h56;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;
  localparam logic [7:0] EXC_NONE      = 8'h00;
  localparam logic [7:0] EXC_FUNCTION  = 8'h01;
  localparam logic [7:0] EXC_ADDRESS   = 8'h02;
  localparam int CLOCK_HZ  = 250000000;
  localparam int BAUD_RATE = 115200;
  localparam int BIT_CYCLES = CLOCK_HZ / BAUD_RATE;

endpackage

//--- rtl/pin_sync.sv
// Two-stage synchroniser for an asynchronous pin
module pin_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);

  // ============================================================
  // Synchroniser stages
  logic stage1;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      stage1  <= pin_i;
      level_o <= stage1;
    end
  end

endmodule

//--- rtl/gripper_control_status_registers.sv
// Gripper command and status register bank with motion goal selection
module gripper_control_status_registers (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        gpio_cmd_i,
  input  wire logic        req_valid_i,
  input  wire logic [7:0]  req_server_i,
  input  wire logic [7:0]  req_func_i,
  input  wire logic [15:0] req_addr_i,
  input  wire logic [15:0] req_wdata_i,
  input  wire logic [15:0] measured_pos_i,
  input  wire logic [15:0] motor_current_i,
  input  wire logic [7:0]  temp_a_i,
  input  wire logic [7:0]  temp_b_i,
  input  wire logic [1:0]  object_detect_i,
  input  wire logic        fingers_moving_i,
  input  wire logic [7:0]  fault_code_i,
  output logic             resp_valid_o,
  output logic [7:0]       resp_func_o,
  output logic [15:0]      resp_addr_o,
  output logic [15:0]      resp_data_o,
  output logic [7:0]       resp_exception_o,
  output logic             active_o,
  output logic             motion_enable_o,
  output logic [15:0]      goal_position_o,
  output logic [7:0]       goal_speed_o,
  output logic [7:0]       goal_torque_o
);

  // ============================================================
  // Address decoding helpers
  function automatic logic is_status_addr(input logic [15:0] a);
    is_status_addr = (a >= gripper_regs_pkg::ADDR_STATE_FLAGS) &&
                     (a <= gripper_regs_pkg::ADDR_STATUS_RSVD);
  endfunction

  function automatic logic is_command_addr(input logic [15:0] a);
    is_command_addr = (a >= gripper_regs_pkg::ADDR_MODE) &&
                      (a <= gripper_regs_pkg::ADDR_PRESET_OPEN);
  endfunction

  function automatic logic [15:0] clamp_target(input logic [15:0] v);
    clamp_target = (v > gripper_regs_pkg::TARGET_LIMIT) ?
                   gripper_regs_pkg::TARGET_LIMIT : v;
  endfunction

  // ============================================================
  // Synchronised command pin
  logic pin_level;

  pin_sync u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (gpio_cmd_i),
    .level_o (pin_level)
  );

  // ============================================================
  // Request classification
  logic for_us;
  logic is_read;
  logic is_write;
  logic wr_en;

  assign for_us   = req_valid_i && (req_server_i == gripper_regs_pkg::SERVER_ADDR);
  assign is_read  = (req_func_i == gripper_regs_pkg::FC_READ_INPUT);
  assign is_write = (req_func_i == gripper_regs_pkg::FC_WRITE_ONE) ||
                    (req_func_i == gripper_regs_pkg::FC_WRITE_MANY);
  assign wr_en    = for_us && is_write && is_command_addr(req_addr_i);

  // ============================================================
  // Command registers
  logic [15:0] mode_reg;
  logic [15:0] target_reg;
  logic [7:0]  speed_reg;
  logic [7:0]  torque_reg;
  logic [7:0]  preset_close;
  logic [7:0]  preset_open;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= gripper_regs_pkg::MODE_RESET;
    end else if (wr_en && req_addr_i == gripper_regs_pkg::ADDR_MODE) begin
      mode_reg <= req_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      target_reg <= gripper_regs_pkg::TARGET_RESET;
    end else if (wr_en && req_addr_i == gripper_regs_pkg::ADDR_TARGET) begin
      target_reg <= req_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      speed_reg  <= gripper_regs_pkg::SPEED_RESET;
      torque_reg <= gripper_regs_pkg::TORQUE_RESET;
    end else if (wr_en) begin
      if (req_addr_i == gripper_regs_pkg::ADDR_SPEED) begin
        speed_reg <= req_wdata_i[7:0];
      end
      if (req_addr_i == gripper_regs_pkg::ADDR_TORQUE) begin
        torque_reg <= req_wdata_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      preset_close <= gripper_regs_pkg::PRESET_CLOSE_RESET;
      preset_open  <= gripper_regs_pkg::PRESET_OPEN_RESET;
    end else if (wr_en) begin
      if (req_addr_i == gripper_regs_pkg::ADDR_PRESET_CLOSE) begin
        preset_close <= req_wdata_i[7:0];
      end
      if (req_addr_i == gripper_regs_pkg::ADDR_PRESET_OPEN) begin
        preset_open <= req_wdata_i[7:0];
      end
    end
  end

  // ============================================================
  // Effective mode decode
  logic act;
  logic motion_ok;
  logic gpio_src;

  assign act       = mode_reg[gripper_regs_pkg::ACTIVATE_BIT];
  assign motion_ok = act && mode_reg[gripper_regs_pkg::MOTION_ENABLE_BIT];
  assign gpio_src  = act && mode_reg[gripper_regs_pkg::SOURCE_BIT];

  // ============================================================
  // Motion goal selection
  logic [15:0] next_goal_position;
  logic [7:0]  preset_pick;

  always_comb begin
    preset_pick = pin_level ? preset_open : preset_close;
    if (gpio_src) begin
      next_goal_position = {8'h00, preset_pick};
    end else begin
      next_goal_position = clamp_target(target_reg);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      goal_position_o <= 16'h0000;
    end else if (motion_ok) begin
      goal_position_o <= next_goal_position;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      goal_speed_o  <= 8'h00;
      goal_torque_o <= 8'h00;
    end else begin
      goal_speed_o  <= speed_reg;
      goal_torque_o <= torque_reg;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_o        <= 1'b0;
      motion_enable_o <= 1'b0;
    end else begin
      active_o        <= act;
      motion_enable_o <= motion_ok;
    end
  end

  // ============================================================
  // Status word assembly
  logic [15:0] state_flags;

  always_comb begin
    state_flags = 16'h0000;
    state_flags[gripper_regs_pkg::ACTIVE_FLAG_POS]    = act;
    state_flags[gripper_regs_pkg::MOTION_ALLOWED_POS] = motion_ok;
    state_flags[gripper_regs_pkg::SOURCE_FIELD_LSB +: 2] =
      gpio_src ? gripper_regs_pkg::SOURCE_GPIO : gripper_regs_pkg::SOURCE_SERIAL;
    state_flags[gripper_regs_pkg::OBJECT_FIELD_LSB +: 2] = object_detect_i;
    state_flags[gripper_regs_pkg::PIN_ECHO_POS]    = pin_level;
    state_flags[gripper_regs_pkg::MOVING_FLAG_POS] = fingers_moving_i;
    state_flags[gripper_regs_pkg::FAULT_FIELD_LSB +: 8] = fault_code_i;
  end

  // ============================================================
  // Read multiplexer
  logic [15:0] read_word;

  always_comb begin
    case (req_addr_i)
      gripper_regs_pkg::ADDR_STATE_FLAGS:   read_word = state_flags;
      gripper_regs_pkg::ADDR_ECHO_TARGET:   read_word = target_reg;
      gripper_regs_pkg::ADDR_MEASURED_POS:  read_word = measured_pos_i;
      gripper_regs_pkg::ADDR_MOTOR_CURRENT: read_word = motor_current_i;
      gripper_regs_pkg::ADDR_DUAL_TEMP:     read_word = {temp_a_i, temp_b_i};
      default:                              read_word = 16'h0000;
    endcase
  end

  // ============================================================
  // Response generation
  logic [7:0]  next_exception;
  logic [15:0] next_data;

  always_comb begin
    next_exception = gripper_regs_pkg::EXC_NONE;
    next_data      = req_wdata_i;
    if (is_read) begin
      if (is_status_addr(req_addr_i)) begin
        next_data = read_word;
      end else begin
        next_exception = gripper_regs_pkg::EXC_ADDRESS;
        next_data      = 16'h0000;
      end
    end else if (is_write) begin
      if (!is_command_addr(req_addr_i)) begin
        next_exception = gripper_regs_pkg::EXC_ADDRESS;
      end
    end else begin
      next_exception = gripper_regs_pkg::EXC_FUNCTION;
      next_data      = 16'h0000;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_valid_o <= 1'b0;
    end else begin
      resp_valid_o <= for_us;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_func_o      <= 8'h00;
      resp_addr_o      <= 16'h0000;
      resp_data_o      <= 16'h0000;
      resp_exception_o <= 8'h00;
    end else if (for_us) begin
      resp_func_o      <= req_func_i;
      resp_addr_o      <= req_addr_i;
      resp_data_o      <= next_data;
      resp_exception_o <= next_exception;
    end
  end

endmodule

//--- testbench/gripper_regs_checker.sv
// Port assertions for the gripper register bank
module gripper_regs_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        req_valid_i,
  input wire logic [7:0]  req_server_i,
  input wire logic [7:0]  req_func_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic        resp_valid_o,
  input wire logic [7:0]  resp_exception_o,
  input wire logic        active_o,
  input wire logic        motion_enable_o,
  input wire logic [15:0] goal_position_o,
  input wire logic [7:0]  goal_speed_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic take = req_valid_i && req_server_i == gripper_regs_pkg::SERVER_ADDR;
  wire logic wr1  = take && req_func_i == gripper_regs_pkg::FC_WRITE_ONE;
  // ============================================================
  // Request steps
  sequence s_mode_off;
    wr1 && req_addr_i == gripper_regs_pkg::ADDR_MODE && !req_wdata_i[0];
  endsequence
  sequence s_mode_run;
    wr1 && req_addr_i == gripper_regs_pkg::ADDR_MODE && req_wdata_i[1:0] == 2'h3;
  endsequence
  sequence s_speed_wr;
    wr1 && req_addr_i == gripper_regs_pkg::ADDR_SPEED;
  endsequence
  sequence s_still;
    !motion_enable_o [*2];
  endsequence
  // ============================================================
  // Properties
  property p_answer;
    take |=> resp_valid_o;
  endproperty
  property p_silent;
    !take |=> !resp_valid_o;
  endproperty
  property p_deact;
    s_mode_off |-> ##2 (!active_o && !motion_enable_o);
  endproperty
  property p_motion;
    s_mode_run |-> ##2 motion_enable_o;
  endproperty
  property p_freeze;
    s_still |-> $stable(goal_position_o);
  endproperty
  property p_limit;
    goal_position_o <= gripper_regs_pkg::TARGET_LIMIT;
  endproperty
  property p_speed;
    s_speed_wr |-> ##2 {8'h00, goal_speed_o} == ($past(req_wdata_i, 2) & 16'h00FF);
  endproperty
  property p_bad_addr;
    take && req_func_i == gripper_regs_pkg::FC_READ_INPUT
      && req_addr_i >= gripper_regs_pkg::ADDR_MODE
      |=> resp_exception_o == gripper_regs_pkg::EXC_ADDRESS;
  endproperty
  property p_bad_func;
    take && !(req_func_i inside {8'h04, 8'h06, 8'h10})
      |=> resp_exception_o == gripper_regs_pkg::EXC_FUNCTION;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  a_silent: assert property (p_silent) else $error("answer without request");
  a_deact: assert property (p_deact) else $error("deactivation ignored");
  a_motion: assert property (p_motion) else $error("motion not enabled");
  a_freeze: assert property (p_freeze) else $error("goal moved while held");
  a_limit: assert property (p_limit) else $error("goal above limit");
  a_speed: assert property (p_speed) else $error("speed low byte wrong");
  a_bad_addr: assert property (p_bad_addr) else $error("bad read not refused");
  a_bad_func: assert property (p_bad_func) else $error("bad function accepted");
endmodule

//--- testbench/finger_plant_model.sv
// Finger drive and encoder model behind the goal outputs
module finger_plant_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] goal_position_i,
  output logic [15:0]      measured_pos_o,
  output logic             fingers_moving_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Encoder reaches the goal one cycle late, in doubled mm
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      measured_pos_o <= 16'h0000;
    end else begin
      measured_pos_o <= goal_position_i;
    end
  end
  assign fingers_moving_o = measured_pos_o != goal_position_i;
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the gripper register bank
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, rst_i = 1, gpio_cmd_i = 0, req_valid_i = 0;
  logic [7:0] req_server_i = 0, req_func_i = 0, temp_a_i = 0, temp_b_i = 0, fault_code_i = 0;
  logic [15:0] req_addr_i = 0, req_wdata_i = 0, motor_current_i = 0, measured_pos_i;
  logic [1:0] object_detect_i = 0;
  logic fingers_moving_i, resp_valid_o, active_o, motion_enable_o;
  logic [7:0] resp_func_o, resp_exception_o, goal_speed_o, goal_torque_o;
  logic [15:0] resp_addr_o, resp_data_o, goal_position_o;
  int miscompares = 0, comparisons = 0, cycles = 0;
  logic seen_valid;
  always #2 clk_i = ~clk_i;
  gripper_control_status_registers u_gripper_control_status_registers (
    .clk_i(clk_i), .rst_i(rst_i), .gpio_cmd_i(gpio_cmd_i), .req_valid_i(req_valid_i),
    .req_server_i(req_server_i), .req_func_i(req_func_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .measured_pos_i(measured_pos_i),
    .motor_current_i(motor_current_i), .temp_a_i(temp_a_i), .temp_b_i(temp_b_i),
    .object_detect_i(object_detect_i), .fingers_moving_i(fingers_moving_i),
    .fault_code_i(fault_code_i), .resp_valid_o(resp_valid_o), .resp_func_o(resp_func_o),
    .resp_addr_o(resp_addr_o), .resp_data_o(resp_data_o),
    .resp_exception_o(resp_exception_o), .active_o(active_o),
    .motion_enable_o(motion_enable_o), .goal_position_o(goal_position_o),
    .goal_speed_o(goal_speed_o), .goal_torque_o(goal_torque_o));
  finger_plant_model u_finger_plant_model (.clk_i(clk_i), .rst_i(rst_i),
    .goal_position_i(goal_position_o), .measured_pos_o(measured_pos_i),
    .fingers_moving_o(fingers_moving_i));
  // ============================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic [7:0] srv, input logic [7:0] fc, input logic [15:0] a,
                      input logic [15:0] d);
    @(negedge clk_i);
    req_valid_i = 1;
    req_server_i = srv;
    req_func_i = fc;
    req_addr_i = a;
    req_wdata_i = d;
    @(negedge clk_i);
    seen_valid = resp_valid_o;
    req_valid_i = 0;
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    xfer(gripper_regs_pkg::SERVER_ADDR, gripper_regs_pkg::FC_WRITE_ONE, a, d);
    check("write answered", seen_valid, 1);
    check("write echo", resp_data_o, d);
    check("write exc", resp_exception_o, gripper_regs_pkg::EXC_NONE);
    repeat (5) @(negedge clk_i);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    xfer(gripper_regs_pkg::SERVER_ADDR, gripper_regs_pkg::FC_READ_INPUT, a, 16'h0000);
    check("read answered", seen_valid, 1);
    check("read func", resp_func_o, gripper_regs_pkg::FC_READ_INPUT);
    check("read addr", resp_addr_o, a);
    check($sformatf("reg %h", a), resp_data_o, exp);
  endtask
  function automatic logic [15:0] stat(logic act, logic mot, logic [1:0] src);
    return {fault_code_i, 1'b0, gpio_cmd_i, object_detect_i, src, mot, act};
  endfunction
  // ============================================================
  // Scenarios
  task automatic t_power_up;
    check("active", active_o, 1);
    check("motion", motion_enable_o, 1);
    check("goal", goal_position_o, 16'h0014);
    rdc(gripper_regs_pkg::ADDR_STATE_FLAGS, stat(1, 1, 2'h1));
    $display("done power_up");
  endtask
  task automatic t_gpio;
    gpio_cmd_i = 1;
    repeat (5) @(negedge clk_i);
    check("goal open", goal_position_o, 16'h00F0);
    rdc(gripper_regs_pkg::ADDR_STATE_FLAGS, stat(1, 1, 2'h1));
    wr(gripper_regs_pkg::ADDR_PRESET_OPEN, 16'h01C8);
    check("goal open preset", goal_position_o, 16'h00C8);
    wr(gripper_regs_pkg::ADDR_PRESET_CLOSE, 16'h0128);
    gpio_cmd_i = 0;
    repeat (2) @(negedge clk_i);
    rdc(gripper_regs_pkg::ADDR_STATE_FLAGS, stat(1, 1, 2'h1) | 16'h0080);
    check("goal close preset", goal_position_o, 16'h0028);
    $display("done gpio");
  endtask
  task automatic t_serial;
    wr(gripper_regs_pkg::ADDR_MODE, 16'h0003);
    wr(gripper_regs_pkg::ADDR_TARGET, 16'h0200);
    check("goal clamp", goal_position_o, 16'h0108);
    rdc(gripper_regs_pkg::ADDR_ECHO_TARGET, 16'h0200);
    gpio_cmd_i = 1;
    repeat (5) @(negedge clk_i);
    check("goal pin ignored", goal_position_o, 16'h0108);
    rdc(gripper_regs_pkg::ADDR_STATE_FLAGS, stat(1, 1, 2'h0));
    wr(gripper_regs_pkg::ADDR_MODE, 16'hFFF3);
    wr(gripper_regs_pkg::ADDR_TARGET, 16'h00F0);
    check("goal high bits", goal_position_o, 16'h00F0);
    wr(gripper_regs_pkg::ADDR_SPEED, 16'h1233);
    wr(gripper_regs_pkg::ADDR_TORQUE, 16'hABCC);
    check("speed", goal_speed_o, 16'h0033);
    check("torque", goal_torque_o, 16'h00CC);
    gpio_cmd_i = 0;
    $display("done serial");
  endtask
  task automatic t_hold;
    wr(gripper_regs_pkg::ADDR_MODE, 16'h0001);
    wr(gripper_regs_pkg::ADDR_TARGET, 16'h0010);
    check("goal held", goal_position_o, 16'h00F0);
    rdc(gripper_regs_pkg::ADDR_STATE_FLAGS, stat(1, 0, 2'h0));
    wr(gripper_regs_pkg::ADDR_MODE, 16'hFFFE);
    check("inactive", active_o, 0);
    rdc(gripper_regs_pkg::ADDR_STATE_FLAGS, stat(0, 0, 2'h0));
    wr(gripper_regs_pkg::ADDR_MODE, 16'h0007);
    check("goal gpio again", goal_position_o, 16'h0028);
    $display("done hold");
  endtask
  task automatic t_status;
    motor_current_i = 16'h002A;
    temp_a_i = 8'h1F;
    temp_b_i = 8'h23;
    for (int i = 0; i < 6; i++) begin
      object_detect_i = 2'(i);
      fault_code_i = 8'(i);
      rdc(gripper_regs_pkg::ADDR_STATE_FLAGS, stat(1, 1, 2'h1));
    end
    rdc(gripper_regs_pkg::ADDR_MEASURED_POS, 16'h0028);
    rdc(gripper_regs_pkg::ADDR_MOTOR_CURRENT, 16'h002A);
    rdc(gripper_regs_pkg::ADDR_DUAL_TEMP, 16'h1F23);
    rdc(gripper_regs_pkg::ADDR_STATUS_RSVD, 16'h0000);
    xfer(8'h56, 8'h04, gripper_regs_pkg::ADDR_MODE, 16'h0000);
    check("exc addr", resp_exception_o, 16'h0002);
    xfer(8'h56, 8'h03, gripper_regs_pkg::ADDR_STATE_FLAGS, 16'h0000);
    check("exc func", resp_exception_o, 16'h0001);
    xfer(8'h55, 8'h04, gripper_regs_pkg::ADDR_STATE_FLAGS, 16'h0000);
    check("wrong server", seen_valid, 0);
    $display("done status");
  endtask
  // ============================================================
  // Run control
  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(negedge clk_i);
    rst_i = 0;
    repeat (4) @(negedge clk_i);
    t_power_up();
    t_gpio();
    t_serial();
    t_hold();
    t_status();
    summarize();
  end
endmodule
bind gripper_control_status_registers gripper_regs_checker u_checker (
  .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_server_i(req_server_i),
  .req_func_i(req_func_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
  .resp_valid_o(resp_valid_o), .resp_exception_o(resp_exception_o), .active_o(active_o),
  .motion_enable_o(motion_enable_o), .goal_position_o(goal_position_o),
  .goal_speed_o(goal_speed_o));
